// *** etwb_defs.vh ***
`ifndef ETWB_DEFS_VH
`define ETWB_DEFS_VH

// apb register byte offsets
`define ETWB_OFF_CTRL 12'h000
`define ETWB_OFF_STATUS 12'h004
`define ETWB_OFF_ADDRWORD 12'h008
`define ETWB_OFF_MISCNT 12'h00c

// control register fields and reset value
`define ETWB_CTRL_EN_BIT 0
`define ETWB_CTRL_HOLD_BIT 1
`define ETWB_CTRL_RST 2'h1

// status register fields
`define ETWB_ST_STANDBY_BIT 0
`define ETWB_ST_BUSY_BIT 1
`define ETWB_ST_RW_BIT 2
`define ETWB_ST_BLK_LSB 4
`define ETWB_ST_PIN_LSB 8
`define ETWB_ST_STATE_LSB 16

// device address word layout
`define ETWB_PREFIX 4'ha
`define ETWB_PREFIX_MSB 7
`define ETWB_PREFIX_LSB 4
`define ETWB_BLK_MSB 3
`define ETWB_BLK_LSB 1
`define ETWB_RW_BIT 0

// serial word length and counter reset values
`define ETWB_WORD_BITS 4'h8
`define ETWB_MIS_RST 16'h0000

`endif

// *** etwb_front.v ***
// Overview of operation
// - data on the serial data line changes only while the clock is low, and a change while it is high is a start or stop, never data.
// - a data-line fall while the clock is high is a start, recognised in every state while the enable bit is set.
// - a data-line rise while the clock is high is a stop, which closes the current operation.
// - every address and data word moves as eight bits, one per clock, most significant first.
// - after each received word the device pulls the data line low during the ninth clock.
// - the device sits in standby after reset, after a stop during a read, and once the timed write finishes.
// - a start, nine clocks, another start and a stop leave the device ready for the next transfer.
// - after each start the first word is the device address word, checked before any read or write.
// - the top four bits of the device address word must be one, zero, one, zero.
// - the next three bits are taken as word address bits ten, nine and eight.
// - the lowest bit picks the operation, one for read and zero for write.
// - a matching address word is acknowledged, a mismatch is not and the device idles until the next start.
// - chip-address pins that are left open read as low.
// - while the timed write runs, inputs are ignored and no acknowledge is given.
`timescale 1ns/1ns
`include "etwb_defs.vh"
module etwb_front (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  // two-wire pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_q,
  output reg sda_oe_q,
  // chip-address pads: level and connected sense
  input wire [2:0] chip_pin_val,
  input wire [2:0] chip_pin_en,
  // read engine
  input wire [7:0] tx_data,
  output reg tx_next_q,
  // write engine
  input wire wr_busy,
  output reg [7:0] rx_data_q,
  output reg rx_valid_q,
  output reg wr_commit_q,
  // operation decode
  output reg op_read_q,
  output reg op_write_q,
  output reg [2:0] block_sel_q,
  output reg stop_q,
  output reg standby_q
);

  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_ADDR = 8'h02;
  localparam [7:0] ST_AACK = 8'h04;
  localparam [7:0] ST_WRX = 8'h08;
  localparam [7:0] ST_WACK = 8'h10;
  localparam [7:0] ST_RTX = 8'h20;
  localparam [7:0] ST_RACK = 8'h40;
  localparam [7:0] ST_IGN = 8'h80;

  // checks prefix of a device address word
  function addr_match;
    input [7:0] word;
    addr_match = (word[`ETWB_PREFIX_MSB:`ETWB_PREFIX_LSB] == `ETWB_PREFIX);
  endfunction

  // true when the byte offset equals the given register offset, whether or not an access is in progress
  function hit;
    input [11:0] addr, off;
    hit = (addr == off);
  endfunction

  wire [7:0] sync_w;
  wire scl_s, sda_s;
  wire [2:0] pin_s;
  reg scl_d_q, sda_d_q, rw_q, wr_seen_q, mack_q;
  reg [7:0] state_q, shift_q, tx_sh_q, addr_q;
  reg [3:0] cnt_q;
  reg [1:0] ctrl_q;
  reg [15:0] mis_q;
  wire scl_rise, scl_fall, start_det, stop_det, busy, enable;
  wire word_done, addr_ok, mis_evt, apb_acc, apb_wr, mis_clr;

  etwb_sync #(
    .W(8),
    .RST_VAL(8'h03)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({chip_pin_en, chip_pin_val, sda_in, scl_in}),
    .sync_q(sync_w)
  );

  assign scl_s = sync_w[0];
  assign sda_s = sync_w[1];
  assign pin_s = sync_w[4:2] & sync_w[7:5];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_q;
  assign scl_fall = ~scl_s & scl_d_q;
  assign start_det = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign stop_det = scl_s & scl_d_q & ~sda_d_q & sda_s;

  assign enable = ctrl_q[`ETWB_CTRL_EN_BIT];
  assign busy = wr_busy | ctrl_q[`ETWB_CTRL_HOLD_BIT];
  assign word_done = scl_fall & (cnt_q == `ETWB_WORD_BITS);
  assign addr_ok = addr_match(shift_q) & ~busy;
  assign mis_evt = enable & ~start_det & ~stop_det & (state_q == ST_ADDR) & word_done & ~addr_ok;

  // protocol engine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_sh_q <= 8'h00;
      addr_q <= 8'h00;
      rw_q <= 1'b0;
      wr_seen_q <= 1'b0;
      mack_q <= 1'b0;
      sda_out_q <= 1'b0;
      sda_oe_q <= 1'b0;
      tx_next_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      wr_commit_q <= 1'b0;
      op_read_q <= 1'b0;
      op_write_q <= 1'b0;
      block_sel_q <= 3'h0;
      stop_q <= 1'b0;
    end else begin
      tx_next_q <= 1'b0;
      rx_valid_q <= 1'b0;
      wr_commit_q <= 1'b0;
      op_read_q <= 1'b0;
      op_write_q <= 1'b0;
      stop_q <= 1'b0;
      sda_out_q <= 1'b0;
      if (!enable) begin
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
        wr_seen_q <= 1'b0;
      end else if (start_det) begin
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
        wr_seen_q <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
        stop_q <= 1'b1;
        wr_commit_q <= wr_seen_q & ~rw_q;
        wr_seen_q <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR: begin
            if (scl_rise && cnt_q != `ETWB_WORD_BITS) begin
              shift_q <= {shift_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (word_done) begin
              if (addr_ok) begin
                sda_oe_q <= 1'b1;
                state_q <= ST_AACK;
                addr_q <= shift_q;
                block_sel_q <= shift_q[`ETWB_BLK_MSB:`ETWB_BLK_LSB];
                rw_q <= shift_q[`ETWB_RW_BIT];
              end else begin
                state_q <= ST_IGN;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              if (rw_q) begin
                op_read_q <= 1'b1;
                tx_sh_q <= tx_data;
                sda_oe_q <= ~tx_data[7];
                tx_next_q <= 1'b1;
                cnt_q <= 4'h1;
                state_q <= ST_RTX;
              end else begin
                op_write_q <= 1'b1;
                sda_oe_q <= 1'b0;
                cnt_q <= 4'h0;
                state_q <= ST_WRX;
              end
            end
          end
          ST_WRX: begin
            if (scl_rise && cnt_q != `ETWB_WORD_BITS) begin
              shift_q <= {shift_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (word_done) begin
              rx_data_q <= shift_q;
              rx_valid_q <= 1'b1;
              wr_seen_q <= 1'b1;
              sda_oe_q <= 1'b1;
              state_q <= ST_WACK;
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              sda_oe_q <= 1'b0;
              cnt_q <= 4'h0;
              state_q <= ST_WRX;
            end
          end
          ST_RTX: begin
            if (word_done) begin
              sda_oe_q <= 1'b0;
              state_q <= ST_RACK;
            end else if (scl_fall) begin
              tx_sh_q <= {tx_sh_q[6:0], 1'b0};
              sda_oe_q <= ~tx_sh_q[6];
              cnt_q <= cnt_q + 4'h1;
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_s;
            end else if (scl_fall) begin
              if (mack_q) begin
                tx_sh_q <= tx_data;
                sda_oe_q <= ~tx_data[7];
                tx_next_q <= 1'b1;
                cnt_q <= 4'h1;
                state_q <= ST_RTX;
              end else begin
                sda_oe_q <= 1'b0;
                state_q <= ST_IGN;
              end
            end
          end
          ST_IDLE, ST_IGN: begin
            sda_oe_q <= 1'b0;
          end
          default: begin
            state_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // standby when idle and not writing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_q <= 1'b1;
    end else begin
      standby_q <= ((state_q == ST_IDLE) | (state_q == ST_IGN)) & ~wr_busy;
    end
  end

  assign apb_acc = psel & penable & ~pready_q;
  // writes land on the edge that completes the transfer
  assign apb_wr = psel & penable & pready_q & pwrite;
  assign mis_clr = apb_wr & hit(paddr, `ETWB_OFF_MISCNT);

  // mismatch counter; an event in the clearing cycle still counts
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mis_q <= `ETWB_MIS_RST;
    end else if (mis_clr) begin
      mis_q <= {15'h0000, mis_evt};
    end else if (mis_evt && mis_q != 16'hffff) begin
      mis_q <= mis_q + 16'h0001;
    end
  end

  // apb slave, one wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `ETWB_CTRL_RST;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= apb_acc;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      if (apb_wr && hit(paddr, `ETWB_OFF_CTRL)) begin
        ctrl_q <= pwdata[1:0];
      end
      if (apb_acc) begin
        if (hit(paddr, `ETWB_OFF_CTRL)) begin
          if (!pwrite) begin
            prdata_q <= {30'h00000000, ctrl_q};
          end
        end else if (hit(paddr, `ETWB_OFF_STATUS)) begin
          prdata_q <= {8'h00, state_q, 5'h00, pin_s, 1'b0, block_sel_q,
                       1'b0, rw_q, busy, standby_q};
        end else if (hit(paddr, `ETWB_OFF_ADDRWORD)) begin
          prdata_q <= {24'h000000, addr_q};
        end else if (hit(paddr, `ETWB_OFF_MISCNT)) begin
          prdata_q <= {16'h0000, mis_q};
        end else begin
          pslverr_q <= 1'b1;
        end
      end
    end
  end

endmodule

// *** etwb_front_tb.sv ***
`timescale 1ns/1ns
`include "etwb_defs.vh"
module etwb_front_tb;
  logic pclk, presetn, psel, penable, pwrite, wr_busy, ack, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [2:0] chip_pin_val, chip_pin_en;
  logic [7:0] tx_data, d;
  wire [31:0] prdata_q;
  wire [7:0] rx_data_q;
  wire [2:0] block_sel_q;
  wire pready_q, pslverr_q, scl_in, sda_in, sda_out_q, sda_oe_q, tx_next_q, rx_valid_q;
  wire wr_commit_q, op_read_q, op_write_q, stop_q, standby_q;
  int n_fail = 0;
  int n_checks = 0;
  int n_w = 0;
  int n_r = 0;
  int n_c = 0;
  int n_tx = 0;
  etwb_front i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
    .pready_q, .pslverr_q, .scl_in, .sda_in, .sda_out_q, .sda_oe_q, .chip_pin_val,
    .chip_pin_en, .tx_data, .tx_next_q, .wr_busy, .rx_data_q, .rx_valid_q, .wr_commit_q,
    .op_read_q, .op_write_q, .block_sel_q, .stop_q, .standby_q);
  etwb_master i_mst (.pclk, .sda_oe(sda_oe_q), .scl(scl_in), .sda_m(), .sda(sda_in));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (op_write_q === 1'b1) n_w++;
    if (op_read_q === 1'b1) n_r++;
    if (wr_commit_q === 1'b1) n_c++;
    if (tx_next_q === 1'b1) n_tx++;
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task end_of_test;
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready_q !== 1'b1);
    rd = prdata_q;
    err = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task mis(input logic [31:0] e);
    apb(1'b0, `ETWB_OFF_MISCNT, 32'h0);
    chk("miscnt", rd, e);
  endtask
  task t_regs;
    apb(1'b0, `ETWB_OFF_CTRL, 32'h0);
    chk("ctrl", rd, {30'h0, `ETWB_CTRL_RST});
    apb(1'b0, `ETWB_OFF_STATUS, 32'h0);
    chk("standby", rd[`ETWB_ST_STANDBY_BIT], 1'b1);
    chk("pins", rd[`ETWB_ST_PIN_LSB +: 3], 3'h5);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", err, 1'b1);
    apb(1'b1, `ETWB_OFF_MISCNT, 32'h0);
    mis(32'h0);
  endtask
  task t_write;
    for (int b = 0; b < 8; b++) begin
      i_mst.start;
      i_mst.wbyte({`ETWB_PREFIX, b[2:0], 1'b0}, ack);
      chk("wr ack", ack, 1'b0);
      i_mst.wbyte({5'h19, b[2:0]}, ack);
      chk("data ack", ack, 1'b0);
      chk("rx data", rx_data_q, {5'h19, b[2:0]});
      chk("blk", block_sel_q, b[2:0]);
      i_mst.stop;
      repeat (8) @(posedge pclk);
      chk("wr op", n_w, b + 1);
      chk("commit", n_c, b + 1);
    end
  endtask
  task t_read;
    i_mst.start;
    i_mst.wbyte({`ETWB_PREFIX, 3'h2, 1'b1}, ack);
    chk("rd ack", ack, 1'b0);
    i_mst.rbyte(1'b0, d);
    chk("rd byte", d, 8'h96);
    i_mst.rbyte(1'b1, d);
    chk("rd byte2", d, 8'h96);
    i_mst.stop;
    repeat (8) @(posedge pclk);
    chk("rd op", n_r, 1);
    chk("tx next", n_tx, 2);
    chk("rd stby", standby_q, 1'b1);
    apb(1'b0, `ETWB_OFF_ADDRWORD, 32'h0);
    chk("addr word", rd, 32'ha5);
  endtask
  task t_bad;
    logic [3:0] bad [4];
    bad = '{4'h2, 4'he, 4'h8, 4'hb};
    foreach (bad[i]) begin
      i_mst.start;
      i_mst.wbyte({bad[i], 4'h0}, ack);
      chk("bad ack", ack, 1'b1);
      i_mst.wbyte(8'h00, ack);
      chk("ign ack", ack, 1'b1);
      i_mst.stop;
    end
    mis(32'h4);
  endtask
  task t_busy;
    wr_busy <= 1'b1;
    i_mst.start;
    i_mst.wbyte(8'ha0, ack);
    chk("busy ack", ack, 1'b1);
    chk("busy stby", standby_q, 1'b0);
    i_mst.stop;
    wr_busy <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("idle stby", standby_q, 1'b1);
    mis(32'h5);
  endtask
  task t_soft;
    i_mst.start;
    i_mst.bitx(1'b1, ack);
    i_mst.bitx(1'b0, ack);
    i_mst.softrst;
    i_mst.start;
    i_mst.wbyte(8'ha0, ack);
    chk("soft ack", ack, 1'b0);
    i_mst.stop;
  endtask
  task t_ctrl;
    apb(1'b1, `ETWB_OFF_CTRL, 32'h3);
    i_mst.start;
    i_mst.wbyte(8'ha0, ack);
    chk("hold ack", ack, 1'b1);
    apb(1'b0, `ETWB_OFF_STATUS, 32'h0);
    chk("hold busy", rd[`ETWB_ST_BUSY_BIT], 1'b1);
    i_mst.stop;
    apb(1'b1, `ETWB_OFF_CTRL, 32'h1);
    i_mst.start;
    apb(1'b1, `ETWB_OFF_CTRL, 32'h0);
    apb(1'b0, `ETWB_OFF_STATUS, 32'h0);
    chk("off state", rd[`ETWB_ST_STATE_LSB +: 8], 8'h01);
    chk("off stby", rd[`ETWB_ST_STANDBY_BIT], 1'b1);
    apb(1'b1, `ETWB_OFF_CTRL, 32'h1);
    i_mst.wbyte(8'ha0, ack);
    chk("off ack", ack, 1'b1);
    i_mst.stop;
    mis(32'h7);
  endtask
  // run needs well under 10000 cycles
  initial begin
    #400000;
    n_fail++;
    end_of_test;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    wr_busy = 1'b0;
    chip_pin_val = 3'h7;
    chip_pin_en = 3'h5;
    tx_data = 8'h96;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs;
    t_write;
    t_read;
    t_bad;
    t_busy;
    t_soft;
    t_ctrl;
    end_of_test;
  end
endmodule
bind etwb_front etwb_properties i_chk (.pclk, .presetn, .scl_in, .sda_in, .sda_out_q,
  .sda_oe_q, .wr_busy, .rx_valid_q, .op_read_q, .op_write_q, .stop_q, .standby_q);

// *** etwb_master.sv ***
`timescale 1ns/1ns
module etwb_master (
  // clock
  input wire pclk,
  // device pull-down enable
  input wire sda_oe,
  // two-wire lines
  output logic scl,
  output logic sda_m,
  output wire sda
);
  // external pull-up: a released line reads high
  assign sda = sda_m & ~sda_oe;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic bitx(input logic b, output logic r);
    hc(1);
    sda_m <= b;
    hc(4);
    scl <= 1'b1;
    hc(2);
    r = sda;
    hc(1);
    scl <= 1'b0;
  endtask
  task automatic start;
    hc(1);
    sda_m <= 1'b1;
    hc(4);
    scl <= 1'b1;
    hc(4);
    sda_m <= 1'b0;
    hc(4);
    scl <= 1'b0;
  endtask
  task automatic stop;
    hc(1);
    sda_m <= 1'b0;
    hc(4);
    scl <= 1'b1;
    hc(4);
    sda_m <= 1'b1;
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) bitx(v[i], x);
    bitx(1'b1, ack);
  endtask
  task automatic rbyte(input logic mack, output logic [7:0] v);
    logic x;
    for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
    bitx(mack, x);
  endtask
  task automatic softrst;
    logic x;
    start;
    for (int i = 0; i < 9; i++) bitx(1'b1, x);
    start;
    stop;
  endtask
endmodule

// *** etwb_properties.sv ***
`timescale 1ns/1ns
module etwb_properties (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // two-wire pins
  input wire scl_in,
  input wire sda_in,
  input wire sda_out_q,
  input wire sda_oe_q,
  // engine side
  input wire wr_busy,
  input wire rx_valid_q,
  input wire op_read_q,
  input wire op_write_q,
  input wire stop_q,
  input wire standby_q
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence start_s;
    scl_in && $fell(sda_in);
  endsequence
  sequence stop_s;
    scl_in && $rose(sda_in);
  endsequence
  sequence ack_bit_s;
    sda_oe_q ##1 sda_oe_q [*6];
  endsequence
  odrain_low_a: assert property (!sda_out_q)
    else $error("sda driven high");
  start_wake_a: assert property (start_s |-> ##[2:6] !standby_q)
    else $error("start not seen");
  stop_seen_a: assert property (stop_s |-> ##[2:6] stop_q)
    else $error("stop not seen");
  stop_idle_a: assert property (stop_q && !wr_busy |-> ##[0:3] standby_q)
    else $error("no standby after stop");
  busy_stby_a: assert property (wr_busy [*2] |-> !standby_q)
    else $error("standby while busy");
  busy_noack_a: assert property (wr_busy [*2] |-> !(op_read_q || op_write_q))
    else $error("operation while busy");
  op_onehot_a: assert property (!(op_read_q && op_write_q))
    else $error("read and write at once");
  addr_acked_a: assert property ((op_read_q || op_write_q) |->
    $past(sda_oe_q) && $past(sda_oe_q, 4)) else $error("operation without ack");
  data_ack_a: assert property (rx_valid_q |-> ##[0:1] ack_bit_s)
    else $error("data word not acked");
endmodule

// *** etwb_sync.v ***
`timescale 1ns/1ns
module etwb_sync #(
  parameter W = 8,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // levels from outside the clock domain
  input wire [W-1:0] async_in,
  // synchronised levels
  output wire [W-1:0] sync_q
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;

  // two flops per bit; the first is read by the second only
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q[i] <= RST_VAL[i];
          s2_q[i] <= RST_VAL[i];
        end else begin
          s1_q[i] <= async_in[i];
          s2_q[i] <= s1_q[i];
        end
      end
    end
  endgenerate

  assign sync_q = s2_q;

endmodule
